// ---- hdl/dot_consts.svh ----
`ifndef DOT_CONSTS_SVH
`define DOT_CONSTS_SVH

// Register byte offsets, one aligned 32-bit word each
`define DOT_ADDR_MR0 5'h00
`define DOT_ADDR_MR1 5'h04
`define DOT_ADDR_MR2 5'h08
`define DOT_ADDR_TIMING 5'h0c
`define DOT_ADDR_STATUS 5'h10
`define DOT_ADDR_WORD_MASK 5'h1c

// Mode register image fields
`define DOT_MR_MASK 32'h0000ffff
`define DOT_MR0_DLL_FAST 12
`define DOT_MR1_NOM_A2 2
`define DOT_MR1_NOM_A6 6
`define DOT_MR1_NOM_A9 9
`define DOT_MR2_WR_A9 9
`define DOT_MR2_WR_A10 10

// Timing register fields
`define DOT_TIM_CWL_LSB 0
`define DOT_TIM_AL_LSB 8
`define DOT_TIM_BMODE_LSB 16
`define DOT_TIM_MASK 32'h00030f0f
`define DOT_TIM_RST 32'h00000005
`define DOT_BMODE_BL8 2'h0
`define DOT_BMODE_OTF 2'h1
`define DOT_BMODE_BC4 2'h2

// Status register fields
`define DOT_ST_ASYNC 2
`define DOT_ST_HOLD_ERR 8
`define DOT_ST_DLLOFF_ERR 9

// Latency figures in clock cycles
`define DOT_ODTL_SUB 5'h02
`define DOT_PIPE_FIXED 5'h03
`define DOT_ODTH4 3'h4
`define DOT_ODTH8 3'h6
`define DOT_CWN4_ADD 3'h4
`define DOT_CWN8_ADD 3'h6
`define DOT_DEPTH 32

// Asynchronous turn-on/off delay, longest figure in ps, rounded down to cycles but never below one
`define DOT_CLK_PS 10000
`define DOT_T_AONPD_MAX_PS 8500
`define DOT_AONPD_CYC \
  (((`DOT_T_AONPD_MAX_PS / `DOT_CLK_PS) < 1) ? 1 : (`DOT_T_AONPD_MAX_PS / `DOT_CLK_PS))

`endif

// ---- hdl/dot_delay_line.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dot_consts.svh"
module dot_delay_line (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] din,
  input wire logic [4:0] sel,
  output logic [2:0] dout
);

  logic [2:0] hist_q [`DOT_DEPTH];

  // Tap k shows the input k+1 cycles after it was presented
  assign dout = hist_q[sel];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < `DOT_DEPTH; i++) begin
        hist_q[i] <= 3'h0;
      end
    end else begin
      hist_q[0] <= din;
      for (int i = 1; i < `DOT_DEPTH; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

endmodule : dot_delay_line
`default_nettype wire

// ---- hdl/dot_odt_ctrl.sv ----
// Overview of operation
// - Termination stays off while the device drives the data lines.
// - Dynamic write termination is enabled when MR2 bit 9 or 10 is set.
// - Nominal strength from MR1 bits 9,6,2; write strength from MR2 bits 10,9.
// - Without writes, nominal strength applies, timed only by the request pin.
// - Termination turns on and off write latency minus two after the request.
// - With dynamic termination, a write selects write strength after latency minus two.
// - Nominal strength returns four (chop) or six (BL8) cycles after turn-off latency.
// - Asynchronous mode only in precharge power-down with DLL frozen by MR0 bit 12.
// - Asynchronous mode applies no additive latency to the request.
// - Asynchronous mode uses fixed time-based delays from the sampled pin.
// - Termination is enabled only if nominal or write strength bits are non-zero.
// - Termination off and request ignored during self-refresh; the code only blocks the output, and requests keep entering the pipeline.
// - Synchronous request delayed by additive latency: latency is CWL plus AL minus two.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dot_consts.svh"
module dot_odt_ctrl
  import dot_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic odt_pin,
  input wire logic wr_cmd_pin,
  input wire logic bc4_pin,
  input wire logic self_refresh,
  input wire logic pd_precharge,
  input wire logic dll_off,
  input wire logic dq_driving,
  output dot_rtt_t rtt_sel,
  output logic [2:0] rtt_nom_code,
  output logic [1:0] rtt_wr_code,
  output logic term_async
);

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : byte_merge

  function automatic logic [4:0] sat_sub(input logic [4:0] a, input logic [4:0] b);
    return (a > b) ? 5'(a - b) : 5'h00;
  endfunction : sat_sub

  // Bus slave state
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] mr0_q;
  logic [31:0] mr1_q;
  logic [31:0] mr2_q;
  logic [31:0] tim_q;
  logic hold_err_q;
  logic dlloff_err_q;

  // Pin synchronisers, order {bc4, write, odt}; all three see equal delay
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  logic odt_prev_q;
  logic [2:0] hold_cnt_q;
  logic [2:0] wr_cnt_q;
  logic [3:0] aon_cnt_q;
  logic async_on_q;
  dot_mode_t mode_q;
  dot_mode_t mode_d;
  logic async_flag_q;
  dot_rtt_t rtt_q;
  dot_rtt_t rtt_d;
  logic [2:0] nom_code_q;
  logic [1:0] wr_code_q;

  wire logic odt_s;
  wire logic wr_s;
  wire logic bc4_s;
  assign odt_s = sync2_q[0];
  assign wr_s = sync2_q[1];
  assign bc4_s = sync2_q[2];

  // Avalon decode: one wait cycle, then the request is accepted
  wire logic req_new;
  wire logic wr_acc;
  wire logic [4:0] word_addr;
  wire logic hit_mr0;
  wire logic hit_mr1;
  wire logic hit_mr2;
  wire logic hit_tim;
  wire logic hit_st;
  wire logic [31:0] st_word;
  wire logic [31:0] rd_mux;
  assign req_new = (avs_read | avs_write) & wait_q;
  assign wr_acc = avs_write & !wait_q;
  assign word_addr = avs_address & `DOT_ADDR_WORD_MASK;
  assign hit_mr0 = word_addr == `DOT_ADDR_MR0;
  assign hit_mr1 = word_addr == `DOT_ADDR_MR1;
  assign hit_mr2 = word_addr == `DOT_ADDR_MR2;
  assign hit_tim = word_addr == `DOT_ADDR_TIMING;
  assign hit_st = word_addr == `DOT_ADDR_STATUS;
  assign st_word = 32'(rtt_q)
                 | (32'(async_flag_q) << `DOT_ST_ASYNC)
                 | (32'(hold_err_q) << `DOT_ST_HOLD_ERR)
                 | (32'(dlloff_err_q) << `DOT_ST_DLLOFF_ERR);
  // Unmapped words read as zero and ignore writes
  assign rd_mux = hit_mr0 ? mr0_q :
                  hit_mr1 ? mr1_q :
                  hit_mr2 ? mr2_q :
                  hit_tim ? tim_q :
                  hit_st ? st_word : 32'h00000000;

  wire logic [31:0] merged;
  assign merged = byte_merge(rd_mux, avs_writedata, avs_byteenable);

  // Configuration decode
  wire logic [3:0] cwl;
  wire logic [3:0] al;
  wire logic [1:0] bmode;
  wire logic [2:0] nom_bits;
  wire logic [1:0] wr_bits;
  wire logic nom_set;
  wire logic dyn_en;
  wire logic term_en;
  wire logic dll_fast;
  assign cwl = tim_q[`DOT_TIM_CWL_LSB +: 4];
  assign al = tim_q[`DOT_TIM_AL_LSB +: 4];
  assign bmode = tim_q[`DOT_TIM_BMODE_LSB +: 2];
  assign nom_bits = {mr1_q[`DOT_MR1_NOM_A9], mr1_q[`DOT_MR1_NOM_A6],
                     mr1_q[`DOT_MR1_NOM_A2]};
  assign wr_bits = {mr2_q[`DOT_MR2_WR_A10], mr2_q[`DOT_MR2_WR_A9]};
  assign nom_set = |nom_bits;
  assign dyn_en = |wr_bits;
  assign term_en = nom_set | dyn_en;
  assign dll_fast = mr0_q[`DOT_MR0_DLL_FAST];

  // Burst chop either fixed in the timing register or taken with the command
  wire logic bc4_eff;
  assign bc4_eff = (bmode == `DOT_BMODE_BC4) | ((bmode == `DOT_BMODE_OTF) & bc4_s);

  // Synchronous latency CWL+AL-2, less the stages that sync and output add
  wire logic [4:0] odtl;
  wire logic [4:0] tap_sel;
  assign odtl = sat_sub(5'(cwl) + 5'(al), `DOT_ODTL_SUB);
  assign tap_sel = sat_sub(odtl, `DOT_PIPE_FIXED);

  wire logic [2:0] tap;
  wire logic tap_odt;
  wire logic tap_wr;
  wire logic tap_bc4;
  dot_delay_line u_line (
    .clock(clock),
    .rstn(rstn),
    .din({bc4_eff, wr_s, odt_s}),
    .sel(tap_sel),
    .dout(tap)
  );
  assign tap_odt = tap[0];
  assign tap_wr = tap[1];
  assign tap_bc4 = tap[2];

  // Asynchronous mode: DLL frozen in precharge power-down only
  wire logic async_cond;
  assign async_cond = pd_precharge & !dll_fast & !dll_off;

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      DOT_MODE_SYNC: begin
        if (async_cond) begin
          mode_d = DOT_MODE_ASYNC;
        end
      end
      DOT_MODE_ASYNC: begin
        if (!async_cond) begin
          mode_d = DOT_MODE_SYNC;
        end
      end
    endcase
  end

  // Pin level followed after a fixed time, bypassing the latency pipeline
  wire logic aon_match;
  wire logic aon_done;
  assign aon_match = odt_s == async_on_q;
  assign aon_done = aon_cnt_q == 4'(`DOT_AONPD_CYC - 1);

  // Write strength window
  wire logic wr_fire;
  wire logic wr_active;
  wire logic [2:0] wr_len;
  wire logic [2:0] wr_cnt_d;
  assign wr_fire = tap_wr & dyn_en & (mode_q == DOT_MODE_SYNC);
  assign wr_len = tap_bc4 ? `DOT_CWN4_ADD : `DOT_CWN8_ADD;
  assign wr_active = dyn_en & (wr_fire | (wr_cnt_q != 3'h0));
  assign wr_cnt_d = wr_fire ? 3'(wr_len - 3'h1) :
                    (wr_cnt_q != 3'h0) ? 3'(wr_cnt_q - 3'h1) : 3'h0;

  wire logic term_on;
  wire logic blocked;
  assign term_on = (mode_q == DOT_MODE_ASYNC) ? async_on_q : tap_odt;
  // Own output drive and self-refresh override the pin; write strength beats nominal
  assign blocked = self_refresh | dq_driving | !term_en;

  always_comb begin
    rtt_d = DOT_RTT_OFF;
    if (!blocked && term_on) begin
      if (wr_active) begin
        rtt_d = DOT_RTT_WR;
      end else if (nom_set) begin
        rtt_d = DOT_RTT_NOM;
      end
    end
  end

  // Request hold check on the far side's behaviour
  wire logic odt_rose;
  wire logic odt_fell;
  wire logic [2:0] hold_base;
  wire logic [2:0] hold_wr;
  wire logic [2:0] hold_d;
  assign odt_rose = odt_s & !odt_prev_q;
  assign odt_fell = !odt_s & odt_prev_q;
  assign hold_base = odt_rose ? `DOT_ODTH4 :
                     (hold_cnt_q != 3'h0) ? 3'(hold_cnt_q - 3'h1) : 3'h0;
  assign hold_wr = bc4_eff ? `DOT_ODTH4 : `DOT_ODTH8;
  assign hold_d = (wr_s && odt_s && hold_wr > hold_base) ? hold_wr : hold_base;

  wire logic hold_viol;
  wire logic dlloff_viol;
  wire logic st_clr_hold;
  wire logic st_clr_dll;
  assign hold_viol = odt_fell & (hold_cnt_q > 3'h1);
  assign dlloff_viol = dll_off & dyn_en;
  assign st_clr_hold = wr_acc & hit_st & avs_byteenable[1] & avs_writedata[`DOT_ST_HOLD_ERR];
  assign st_clr_dll = wr_acc & hit_st & avs_byteenable[1] & avs_writedata[`DOT_ST_DLLOFF_ERR];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= !req_new;
      if (req_new) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mr0_q <= 32'h00000000;
      mr1_q <= 32'h00000000;
      mr2_q <= 32'h00000000;
      tim_q <= `DOT_TIM_RST;
    end else if (wr_acc) begin
      if (hit_mr0) mr0_q <= merged & `DOT_MR_MASK;
      if (hit_mr1) mr1_q <= merged & `DOT_MR_MASK;
      if (hit_mr2) mr2_q <= merged & `DOT_MR_MASK;
      if (hit_tim) tim_q <= merged & `DOT_TIM_MASK;
    end
  end

  // Sticky errors: a new event in the clearing cycle keeps the bit set
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hold_err_q <= 1'b0;
      dlloff_err_q <= 1'b0;
    end else begin
      hold_err_q <= hold_viol | (hold_err_q & !st_clr_hold);
      dlloff_err_q <= dlloff_viol | (dlloff_err_q & !st_clr_dll);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      odt_prev_q <= 1'b0;
      hold_cnt_q <= 3'h0;
    end else begin
      sync1_q <= {bc4_pin, wr_cmd_pin, odt_pin};
      sync2_q <= sync1_q;
      odt_prev_q <= odt_s;
      hold_cnt_q <= hold_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_q <= DOT_MODE_SYNC;
      async_flag_q <= 1'b0;
      aon_cnt_q <= 4'h0;
      async_on_q <= 1'b0;
      wr_cnt_q <= 3'h0;
    end else begin
      mode_q <= mode_d;
      async_flag_q <= mode_d == DOT_MODE_ASYNC;
      aon_cnt_q <= (aon_match | aon_done) ? 4'h0 : 4'(aon_cnt_q + 4'h1);
      async_on_q <= (!aon_match & aon_done) ? odt_s : async_on_q;
      wr_cnt_q <= wr_cnt_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rtt_q <= DOT_RTT_OFF;
      nom_code_q <= 3'h0;
      wr_code_q <= 2'h0;
    end else begin
      rtt_q <= rtt_d;
      nom_code_q <= nom_bits;
      wr_code_q <= wr_bits;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign rtt_sel = rtt_q;
  assign rtt_nom_code = nom_code_q;
  assign rtt_wr_code = wr_code_q;
  assign term_async = async_flag_q;

  // Checks
  wire logic calm;
  wire logic wr_hold;
  assign calm = (mode_q == DOT_MODE_SYNC) & !async_cond & !blocked & nom_set & (tap_sel == 5'h00);
  assign wr_hold = !blocked & term_on & dyn_en & (mode_q == DOT_MODE_SYNC) & !async_cond;

  sequence s_odt_up;
    (odt_rose && calm) ##1 calm;
  endsequence

  sequence s_odt_down;
    (odt_fell && calm) ##1 calm;
  endsequence

  sequence s_bc4_burst;
    (wr_fire && tap_bc4 && wr_hold) ##1 (wr_hold && !tap_wr)[*3];
  endsequence

  a_self_refresh_off: assert property (@(posedge clock) disable iff (!rstn)
    self_refresh |=> rtt_q == DOT_RTT_OFF)
    else $error("termination on during self-refresh");

  a_drive_overlap_off: assert property (@(posedge clock) disable iff (!rstn)
    dq_driving |=> rtt_q == DOT_RTT_OFF)
    else $error("termination overlaps output drive");

  a_disabled_off: assert property (@(posedge clock) disable iff (!rstn)
    (!term_en && odt_s) |=> rtt_q == DOT_RTT_OFF)
    else $error("termination on while disabled");

  a_turn_on_lat: assert property (@(posedge clock) disable iff (!rstn)
    s_odt_up |-> ##1 rtt_q != DOT_RTT_OFF)
    else $error("termination not on at turn-on latency");

  a_turn_off_lat: assert property (@(posedge clock) disable iff (!rstn)
    s_odt_down |-> ##1 rtt_q == DOT_RTT_OFF)
    else $error("termination not off at turn-off latency");

  a_wr_switch: assert property (@(posedge clock) disable iff (!rstn)
    (wr_fire && wr_hold) |=> rtt_q == DOT_RTT_WR)
    else $error("write strength not selected");

  a_wr_bc4_hold: assert property (@(posedge clock) disable iff (!rstn)
    s_bc4_burst |=> rtt_q == DOT_RTT_WR)
    else $error("write strength ended early");

  a_wr_bc4_return: assert property (@(posedge clock) disable iff (!rstn)
    s_bc4_burst ##1 (wr_hold && !tap_wr) |=> rtt_q != DOT_RTT_WR)
    else $error("write strength held too long");

  a_hold_violation: assert property (@(posedge clock) disable iff (!rstn)
    (odt_rose && !wr_s) ##1 !odt_s |=> hold_err_q)
    else $error("early request release not flagged");

  a_dlloff_dynamic: assert property (@(posedge clock) disable iff (!rstn)
    (dll_off && dyn_en) |=> dlloff_err_q)
    else $error("dynamic termination in DLL-off not flagged");

  a_async_follow: assert property (@(posedge clock) disable iff (!rstn)
    (odt_rose && mode_q == DOT_MODE_ASYNC) ##1 (odt_s && mode_q == DOT_MODE_ASYNC)[*2]
      |-> async_on_q)
    else $error("asynchronous termination did not follow pin");

  a_strength_codes: assert property (@(posedge clock) disable iff (!rstn)
    ##1 (rtt_nom_code == $past(nom_bits)) && (rtt_wr_code == $past(wr_bits)))
    else $error("strength code mismatch");

endmodule : dot_odt_ctrl
`default_nettype wire

// ---- hdl/dot_pkg.sv ----
package dot_pkg;

  typedef enum logic [1:0] {
    DOT_RTT_OFF,
    DOT_RTT_NOM,
    DOT_RTT_WR
  } dot_rtt_t;

  typedef enum logic {
    DOT_MODE_SYNC,
    DOT_MODE_ASYNC
  } dot_mode_t;

endpackage : dot_pkg

// ---- verif/dot_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dot_ctrl_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic go,
  input wire logic rd,
  input wire logic bad,
  input wire logic [3:0] len,
  input wire logic [2:0] wr_off,
  input wire logic bc4_in,
  output logic odt_pin,
  output logic wr_cmd_pin,
  output logic bc4_pin,
  output logic dq_driving,
  output logic busy
);
  logic [3:0] cnt_q;
  logic [3:0] tgt_q;
  logic [2:0] wof_q;
  wire logic [3:0] base = (len < 4'h4) ? 4'h4 : len;
  wire logic [3:0] wend = {1'b0, wr_off} + 4'h6;
  wire logic [3:0] hold = (wr_off != 3'h0 && wend > base) ? wend : base;
  assign busy = (cnt_q != 4'h0);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      tgt_q <= 4'h0;
      wof_q <= 3'h0;
      odt_pin <= 1'b0;
      wr_cmd_pin <= 1'b0;
      bc4_pin <= 1'b0;
      dq_driving <= 1'b0;
    end else begin
      wr_cmd_pin <= 1'b0;
      // Burst flag is only meaningful with a write, so it wanders otherwise
      bc4_pin <= ~bc4_pin;
      if (cnt_q == 4'h0) begin
        if (go) begin
          odt_pin <= 1'b1;
          // A one-cycle request breaks the hold window from its first sample
          tgt_q <= bad ? 4'h1 : hold;
          wof_q <= wr_off;
          cnt_q <= 4'h1;
        end else if (rd) begin
          dq_driving <= 1'b1;
          tgt_q <= 4'h6;
          wof_q <= 3'h0;
          cnt_q <= 4'h1;
        end
      end else if (cnt_q == tgt_q) begin
        odt_pin <= 1'b0;
        dq_driving <= 1'b0;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q[2:0] == wof_q && cnt_q < 4'h8) begin
          wr_cmd_pin <= 1'b1;
          bc4_pin <= bc4_in;
        end
      end
    end
  end
endmodule : dot_ctrl_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dot_pkg::*;
  logic clock, rstn, avs_read, avs_write, avs_waitrequest, self_refresh, pd_precharge, dll_off;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, x, q;
  logic [3:0] avs_byteenable, len;
  logic odt_pin, wr_cmd_pin, bc4_pin, dq_driving, busy, go, rd, bad, bc4_in, amode, chk_on;
  logic [2:0] wr_off, nomb, rtt_nom_code;
  logic [1:0] wrb, bm, rtt_wr_code;
  logic term_async;
  dot_rtt_t rtt_sel;
  int errors, checks, seed, cyc, lat, k, i;
  logic s_odt [64];
  logic s_wr [64];
  logic s_ovr [64];
  logic [2:0] s_len [64];
  dot_odt_ctrl dut_u (.clock(clock), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .odt_pin(odt_pin), .wr_cmd_pin(wr_cmd_pin),
    .bc4_pin(bc4_pin), .self_refresh(self_refresh), .pd_precharge(pd_precharge),
    .dll_off(dll_off), .dq_driving(dq_driving), .rtt_sel(rtt_sel),
    .rtt_nom_code(rtt_nom_code), .rtt_wr_code(rtt_wr_code), .term_async(term_async));
  dot_ctrl_model ctrl_u (.clock(clock), .rstn(rstn), .go(go), .rd(rd), .bad(bad), .len(len),
    .wr_off(wr_off), .bc4_in(bc4_in), .odt_pin(odt_pin), .wr_cmd_pin(wr_cmd_pin),
    .bc4_pin(bc4_pin), .dq_driving(dq_driving), .busy(busy));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic final_report;
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: value %h, expected %h", $time, g, e);
    end
  endtask : cmp32
  task automatic cmp_rtt(input dot_rtt_t g, input dot_rtt_t e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: strength %0d, expected %0d", $time, g, e);
    end
  endtask : cmp_rtt
  task automatic bus_op(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    q = avs_readdata;
    if (n >= 20) errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus_op
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus_op(1'b0, a, 32'h0);
    cmp32(q, e);
  endtask : rd_chk
  // Expected strength after edge t, from what the pins held at edge t (override) and at earlier edges
  function automatic dot_rtt_t exp_rtt(input int t);
    int d;
    int w;
    logic on;
    on = amode ? s_odt[(t - 3) & 63] : s_odt[(t - lat) & 63];
    w = 9;
    for (d = 5; d >= 0; d--) if (s_wr[(t - lat - d) & 63] === 1'b1) w = d;
    if (on !== 1'b1 || s_ovr[t & 63]) return DOT_RTT_OFF;
    if (!amode && w < 9 && w < s_len[(t - lat - w) & 63] && wrb != 2'h0) return DOT_RTT_WR;
    return (nomb != 3'h0) ? DOT_RTT_NOM : DOT_RTT_OFF;
  endfunction : exp_rtt
  always begin
    @(posedge clock);
    cyc = cyc + 1;
    s_odt[cyc & 63] = odt_pin;
    s_wr[cyc & 63] = wr_cmd_pin;
    s_ovr[cyc & 63] = self_refresh | dq_driving;
    s_len[cyc & 63] = (bm == 2'h0 || (bm == 2'h1 && !bc4_pin)) ? 3'h6 : 3'h4;
    #1;
    if (chk_on) cmp_rtt(rtt_sel, exp_rtt(cyc));
  end
  task automatic cfg(input logic [2:0] nm, input logic [1:0] wm, input logic [3:0] c, a,
                     input logic [1:0] b, input logic p);
    chk_on = 1'b0;
    bus_op(1'b1, 5'h04, {22'h0, nm[2], 2'h0, nm[1], 3'h0, nm[0], 2'h0});
    bus_op(1'b1, 5'h08, {21'h0, wm, 9'h0});
    bus_op(1'b1, 5'h00, {19'h0, p, 12'h0});
    bus_op(1'b1, 5'h0c, {14'h0, b, 4'h0, a, 4'h0, c});
    cmp32({29'h0, rtt_nom_code}, {29'h0, nm});
    cmp32({30'h0, rtt_wr_code}, {30'h0, wm});
    nomb = nm;
    wrb = wm;
    bm = b;
    lat = c + a - 2;
    if (lat < 3) lat = 3;
    repeat (20) @(posedge clock);
    chk_on = 1'b1;
  endtask : cfg
  task automatic pulse_go(input logic [3:0] l, input logic [2:0] w, input logic b4);
    len <= l;
    wr_off <= w;
    bc4_in <= b4;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
    while (busy) @(posedge clock);
  endtask : pulse_go
  task automatic run_ops(input int n);
    for (int j = 0; j < n; j++) begin
      x = $random(seed);
      pd_precharge <= amode | x[13];
      if (x[1:0] < 2'h2) pulse_go(x[5:2], x[8] ? 3'h1 + {1'b0, x[10:9]} : 3'h0, x[12]);
      else if (x[1:0] == 2'h2) begin
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        repeat (8) @(posedge clock);
      end else begin
        // Long enough to drain the deepest pipeline while ignored
        self_refresh <= 1'b1;
        repeat (12) @(posedge clock);
        self_refresh <= 1'b0;
        @(posedge clock);
      end
      cmp32({31'h0, term_async}, {31'h0, amode});
    end
  endtask : run_ops
  initial begin
    seed = 51402;
    {rstn, avs_read, avs_write, self_refresh, pd_precharge, dll_off} = 6'h00;
    {go, rd, bad, bc4_in, amode, chk_on} = 6'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    len = 4'h0;
    wr_off = 3'h0;
    {nomb, wrb, bm} = 7'h00;
    lat = 3;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd_chk(5'h00, 32'h0);
    rd_chk(5'h04, 32'h0);
    rd_chk(5'h08, 32'h0);
    rd_chk(5'h0c, 32'h5);
    rd_chk(5'h10, 32'h0);
    bus_op(1'b1, 5'h14, 32'hffffffff);
    rd_chk(5'h14, 32'h0);
    x = $random(seed);
    bus_op(1'b1, 5'h04, x);
    rd_chk(5'h04, x & 32'h0000ffff);
    // Only lane 1 may change on a partial write
    avs_byteenable <= 4'h2;
    bus_op(1'b1, 5'h04, 32'hffffffff);
    avs_byteenable <= 4'hf;
    rd_chk(5'h04, (x & 32'h000000ff) | 32'h0000ff00);
    for (k = 0; k < 12; k++) begin
      x = $random(seed);
      cfg(x[2:0], x[4:3], k == 1 ? 4'h9 : 4'h5 + {2'h0, x[6:5]}, k == 0 ? 4'h0 : {2'h0, x[9:8]},
          (x[11:10] == 2'h3) ? 2'h1 : x[11:10], 1'b1);
      run_ops(14);
    end
    pd_precharge <= 1'b0;
    cfg(3'h2, 2'h1, 4'h5, 4'h4, 2'h0, 1'b0);
    chk_on = 1'b0;
    amode = 1'b1;
    pd_precharge <= 1'b1;
    repeat (8) @(posedge clock);
    chk_on = 1'b1;
    run_ops(12);
    chk_on = 1'b0;
    amode = 1'b0;
    pd_precharge <= 1'b0;
    cfg(3'h1, 2'h2, 4'h5, 4'h0, 2'h0, 1'b1);
    chk_on = 1'b0;
    bad <= 1'b1;
    pulse_go(4'h0, 3'h0, 1'b0);
    bad <= 1'b0;
    repeat (12) @(posedge clock);
    rd_chk(5'h10, 32'h100);
    bus_op(1'b1, 5'h10, 32'h100);
    rd_chk(5'h10, 32'h0);
    dll_off <= 1'b1;
    repeat (4) @(posedge clock);
    dll_off <= 1'b0;
    rd_chk(5'h10, 32'h200);
    bus_op(1'b1, 5'h10, 32'h200);
    rd_chk(5'h10, 32'h0);
    final_report();
  end
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
